//--- bench/light_prox_regs_test.sv
// Testbench of the sensor register bank with shortened timing counts.
// Assumes the host model on the register port; converters are driven here.
`timescale 1ns/1ps
`default_nettype none
module light_prox_regs_test;
   localparam int unsigned CONV = 20;
   localparam int unsigned UNIT = 10;
   localparam int unsigned AMBP = 50;
   typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] e;} row_t;
   logic        i_clock = 1'b0;
   logic        i_reset = 1'b1;
   logic        wr, rd, led, drive, span, spec, pin_out, pin_oe;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata, d;
   logic [7:0]  near = 8'h90;
   logic [11:0] amb = 12'h345;
   int          miscompares = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          n;
   logic [7:0]  rst_tab [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00,
      8'hf0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   int          idle_tab [8] = '{64, 32, 16, 8, 6, 4, 1, 0};
   // Test registers written only as zero 0x0 only as a refusal
   row_t        rows [12] = '{'{4'h1, 8'h0b, 8'h0b}, '{4'h2, 8'hff, 8'h67},
      '{4'h3, 8'h12, 8'h12}, '{4'h4, 8'h80, 8'h80}, '{4'h5, 8'h00, 8'h00},
      '{4'h6, 8'h00, 8'h00}, '{4'h7, 8'h30, 8'h30}, '{4'h8, 8'h55, 8'h00},
      '{4'h0, 8'haa, 8'h00}, '{4'hc, 8'haa, 8'h00}, '{4'he, 8'h00, 8'h00},
      '{4'hf, 8'h00, 8'h00}};

   always #12.5 i_clock = ~i_clock;

   light_prox_regs #(.NEAR_CONV_CYCLES(CONV), .IDLE_UNIT_CYCLES(UNIT),
      .AMB_PERIOD_CYCLES(AMBP)) light_prox_regs_i (.i_clock(i_clock),
      .i_reset(i_reset), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_near_adc_value(near),
      .i_ambient_adc_value(amb), .o_led_sink_pin(led),
      .o_led_drive_level(drive), .o_lux_span_select(span),
      .o_spectrum_select(spec), .o_event_pin_out(pin_out),
      .o_event_pin_oe(pin_oe));
   reg_host_model reg_host_model_i (.i_clock(i_clock), .o_wr(wr), .o_rd(rd),
      .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata));

   task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask : check_byte
   task automatic check_count(input int g, input int e);
      tests_run++;
      if (g < e - 2 || g > e + 2) begin
         miscompares++;
         $display("MISMATCH %0t count %0d expected %0d", $time, g, e);
      end
   endtask : check_count
   // Bounded wait for the LED sink to reach a level, sampled mid-cycle
   task automatic wait_led(input logic lvl, output int k);
      k = 0;
      while (led !== lvl && k < 2000) begin
         @(negedge i_clock);
         k++;
      end
   endtask : wait_led
   task automatic check_reg(input logic [3:0] a, input logic [7:0] e);
      reg_host_model_i.read(a, d);
      check_byte(d, e);
   endtask : check_reg
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         give_verdict();
      end
   end

   initial begin
      repeat (20) @(posedge i_clock);
      i_reset <= 1'b0;
      for (int i = 0; i < 16; i++)
         check_reg(i[3:0], rst_tab[i]);
      foreach (rows[i]) begin
         reg_host_model_i.write(rows[i].a, rows[i].w);
         check_reg(rows[i].a, rows[i].e);
      end
      check_byte({5'h00, drive, span, spec}, 8'h07);
      reg_host_model_i.write(4'h2, 8'h00);
      reg_host_model_i.write(4'h1, 8'hf0);
      repeat (CONV + 8) @(posedge i_clock);
      check_reg(4'h8, 8'h90);
      check_reg(4'h2, 8'h80);
      check_byte({6'h00, pin_out, pin_oe}, 8'h01);
      @(posedge i_clock) near <= 8'h00;
      repeat (2 * CONV + 8) @(posedge i_clock);
      check_reg(4'h2, 8'h80);
      reg_host_model_i.write(4'h2, 8'h00);
      check_reg(4'h2, 8'h00);
      check_byte({7'h00, pin_oe}, 8'h00);
      // First gap may still use the old code, so measure the second
      for (int c = 0; c < 7; c++) begin
         reg_host_model_i.write(4'h1, {1'b1, c[2:0], 4'h0});
         wait_led(1'b0, n);
         wait_led(1'b1, n);
         wait_led(1'b0, n);
         wait_led(1'b1, n);
         check_count(n, idle_tab[c] * UNIT);
      end
      reg_host_model_i.write(4'h1, 8'h00);
      repeat (2) @(negedge i_clock);
      check_byte({7'h00, led}, 8'h00);
      reg_host_model_i.write(4'h2, 8'h02);
      reg_host_model_i.write(4'h1, 8'h04);
      repeat (3 * AMBP + AMBP / 2) @(posedge i_clock);
      check_reg(4'h2, 8'h02);
      repeat (AMBP) @(posedge i_clock);
      check_reg(4'h2, 8'h0a);
      check_reg(4'h9, 8'h45);
      check_reg(4'ha, 8'h03);
      check_byte({7'h00, pin_oe}, 8'h01);
      reg_host_model_i.write(4'h2, 8'h0b);
      @(negedge i_clock);
      check_byte({7'h00, pin_oe}, 8'h00);
      // Reset in mid-run must bring back the power-on values
      @(posedge i_clock) i_reset <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_reset <= 1'b0;
      check_reg(4'h2, 8'h00);
      check_reg(4'h4, 8'hff);
      check_byte({6'h00, led, pin_oe}, 8'h00);
      give_verdict();
   end
endmodule : light_prox_regs_test
`default_nettype wire

//--- bench/reg_host_model.sv
// Host model: byte writes and reads on the register port.
// Assumes read data is registered one cycle after the read edge.
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
   // Clock
   input  wire logic       i_clock,
   // Register port
   output logic            o_wr,
   output logic            o_rd,
   output logic [3:0]      o_addr,
   output logic [7:0]      o_wdata,
   input  wire logic [7:0] i_rdata
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 4'h5;
      o_wdata = 8'h5a;
   end
   // Released lines show the inverse, never a stale copy
   task automatic release_bus();
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      o_addr <= ~o_addr;
      o_wdata <= ~o_wdata;
   endtask : release_bus
   // Flags are cleared only by writing zero to them or by reset
   task automatic write(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clock);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clock);
      release_bus();
   endtask : write
   task automatic read(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_clock);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clock);
      release_bus();
      @(negedge i_clock);
      d = i_rdata;
   endtask : read
endmodule : reg_host_model
`default_nettype wire

//--- core/light_prox_pkg.sv
// Constants shared by the light and proximity sensor register bank.
// Assumes a 40 MHz core clock; all timing counts derive from it.
package light_prox_pkg;

   // Register addresses (byte-wide registers, 4-bit address)
   localparam logic [3:0] ADDR_RESERVED = 4'h0;
   localparam logic [3:0] ADDR_CFG      = 4'h1;
   localparam logic [3:0] ADDR_EVT      = 4'h2;
   localparam logic [3:0] ADDR_NEAR_LO  = 4'h3;
   localparam logic [3:0] ADDR_NEAR_HI  = 4'h4;
   localparam logic [3:0] ADDR_AMB_LO   = 4'h5;
   localparam logic [3:0] ADDR_AMB_MIX  = 4'h6;
   localparam logic [3:0] ADDR_AMB_HI   = 4'h7;
   localparam logic [3:0] ADDR_NEAR_RES = 4'h8;
   localparam logic [3:0] ADDR_AMB_RL   = 4'h9;
   localparam logic [3:0] ADDR_AMB_RH   = 4'ha;
   localparam logic [3:0] ADDR_TEST_MODE_ONE    = 4'he;
   localparam logic [3:0] ADDR_TEST_MODE_TWO    = 4'hf;

   // Reset values
   localparam logic [7:0] RST_ZERO    = 8'h00;
   localparam logic [7:0] RST_NEAR_HI = 8'hff;
   localparam logic [7:0] RST_AMB_MIX = 8'hf0;
   localparam logic [7:0] RST_AMB_HI  = 8'hff;

   // Field positions in sense_configuration
   localparam int CFG_NEAR_ON   = 7;
   localparam int CFG_IDLE_LSB  = 4;
   localparam int CFG_DRIVE     = 3;
   localparam int CFG_AMB_ON    = 2;
   localparam int CFG_SPAN      = 1;
   localparam int CFG_SPECTRUM  = 0;

   // Field positions in event_control
   localparam int EVT_NEAR_FLAG    = 7;
   localparam int EVT_NEAR_PERSIST = 5;
   localparam int EVT_AMB_FLAG     = 3;
   localparam int EVT_AMB_PERSIST  = 1;
   localparam int EVT_PIN_AND      = 0;

   // Timing
   localparam int unsigned CLOCK_PERIOD_NS = 25;
   localparam int unsigned NEAR_CONV_NS    = 540000;
   localparam int unsigned NEAR_CONV_CYCLES =
      (NEAR_CONV_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int unsigned IDLE_UNIT_NS    = 12500000;
   localparam int unsigned IDLE_UNIT_CYCLES = IDLE_UNIT_NS / CLOCK_PERIOD_NS;
   localparam int unsigned AMB_PERIOD_NS   = 100000000;
   localparam int unsigned AMB_PERIOD_CYCLES =
      AMB_PERIOD_NS / CLOCK_PERIOD_NS;

   // Idle time between LED pulses in 12.5 ms units
   function automatic logic [6:0] idle_units(input logic [2:0] code);
      case (code)
         3'h7:    idle_units = 7'h00;
         3'h6:    idle_units = 7'h01;
         3'h5:    idle_units = 7'h04;
         3'h4:    idle_units = 7'h06;
         3'h3:    idle_units = 7'h08;
         3'h2:    idle_units = 7'h10;
         3'h1:    idle_units = 7'h20;
         default: idle_units = 7'h40;
      endcase
   endfunction : idle_units

   // Consecutive tripping conversions needed per persistence code
   function automatic logic [4:0] persist_need(input logic [1:0] code);
      case (code)
         2'h0:    persist_need = 5'h01;
         2'h1:    persist_need = 5'h04;
         2'h2:    persist_need = 5'h08;
         default: persist_need = 5'h10;
      endcase
   endfunction : persist_need

endpackage : light_prox_pkg

//--- core/light_prox_regs.sv
// Register bank and sensing sequencer of an ambient light and
// proximity sensor. Assumes a byte register port from a serial slave on
// the same clock; converter outputs arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module light_prox_regs #(
   parameter int unsigned NEAR_CONV_CYCLES  = light_prox_pkg::NEAR_CONV_CYCLES,
   parameter int unsigned IDLE_UNIT_CYCLES  = light_prox_pkg::IDLE_UNIT_CYCLES,
   parameter int unsigned AMB_PERIOD_CYCLES = light_prox_pkg::AMB_PERIOD_CYCLES
) (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   // Register port
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [3:0]  i_reg_addr,
   input  wire logic [7:0]  i_reg_wdata,
   output logic      [7:0]  o_reg_rdata,
   // Converter values, asynchronous
   input  wire logic [7:0]  i_near_adc_value,
   input  wire logic [11:0] i_ambient_adc_value,
   // Analog front end controls
   output logic             o_led_sink_pin,
   output logic             o_led_drive_level,
   output logic             o_lux_span_select,
   output logic             o_spectrum_select,
   // Open-drain event pin
   output logic             o_event_pin_out,
   output logic             o_event_pin_oe
);

   typedef enum logic [1:0] {
      NEAR_OFF     = 2'b00,
      NEAR_CONVERT = 2'b01,
      NEAR_IDLE    = 2'b10
   } near_state_t;

   near_state_t near_state_r;
   logic [7:0]  cfg_r;
   logic        near_event_flag_r;
   logic        ambient_event_flag_r;
   logic [1:0]  near_persist_count_r;
   logic [1:0]  ambient_persist_count_r;
   logic        pin_and_r;
   logic [7:0]  near_low_limit_r;
   logic [7:0]  near_high_limit_r;
   logic [11:0] ambient_low_limit_r;
   logic [11:0] ambient_high_limit_r;
   logic [7:0]  near_result_r;
   logic [11:0] ambient_result_value_r;
   logic [7:0]  test_mode_one_r;
   logic [7:0]  test_mode_two_r;
   logic [7:0]  near_meta_r;
   logic [7:0]  near_sync_r;
   logic [11:0] amb_meta_r;
   logic [11:0] amb_sync_r;
   logic [31:0] near_timer_r;
   logic [31:0] amb_timer_r;
   logic        near_zone_r;
   logic        near_on;
   logic        ambient_sense_on;
   logic [31:0] idle_target;
   logic        near_valid;
   logic        amb_valid;
   logic        near_trip;
   logic        amb_trip;
   logic        near_event;
   logic        amb_event;
   logic        evt_wr;

   assign near_on          = cfg_r[light_prox_pkg::CFG_NEAR_ON];
   assign ambient_sense_on = cfg_r[light_prox_pkg::CFG_AMB_ON];
   assign evt_wr = i_reg_wr && (i_reg_addr == light_prox_pkg::ADDR_EVT);

   // Converter buses change only at conversion ends, far from sampling
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         near_meta_r <= 8'h00;
         near_sync_r <= 8'h00;
         amb_meta_r  <= 12'h000;
         amb_sync_r  <= 12'h000;
      end else begin
         near_meta_r <= i_near_adc_value;
         near_sync_r <= near_meta_r;
         amb_meta_r  <= i_ambient_adc_value;
         amb_sync_r  <= amb_meta_r;
      end
   end

   // Register writes; reserved and unlisted addresses fall through
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         cfg_r                   <= light_prox_pkg::RST_ZERO;
         near_persist_count_r    <= 2'h0;
         ambient_persist_count_r <= 2'h0;
         pin_and_r               <= 1'b0;
         near_low_limit_r        <= light_prox_pkg::RST_ZERO;
         near_high_limit_r       <= light_prox_pkg::RST_NEAR_HI;
         ambient_low_limit_r     <= {light_prox_pkg::RST_AMB_MIX[3:0],
                                     light_prox_pkg::RST_ZERO};
         ambient_high_limit_r    <= {light_prox_pkg::RST_AMB_HI,
                                     light_prox_pkg::RST_AMB_MIX[7:4]};
         test_mode_one_r         <= light_prox_pkg::RST_ZERO;
         test_mode_two_r         <= light_prox_pkg::RST_ZERO;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            light_prox_pkg::ADDR_CFG: cfg_r <= i_reg_wdata;
            light_prox_pkg::ADDR_EVT: begin
               near_persist_count_r    <= i_reg_wdata[6:5];
               ambient_persist_count_r <= i_reg_wdata[2:1];
               pin_and_r <= i_reg_wdata[light_prox_pkg::EVT_PIN_AND];
            end
            light_prox_pkg::ADDR_NEAR_LO: near_low_limit_r <= i_reg_wdata;
            light_prox_pkg::ADDR_NEAR_HI: near_high_limit_r <= i_reg_wdata;
            light_prox_pkg::ADDR_AMB_LO:
               ambient_low_limit_r[7:0] <= i_reg_wdata;
            light_prox_pkg::ADDR_AMB_MIX: begin
               ambient_high_limit_r[3:0] <= i_reg_wdata[7:4];
               ambient_low_limit_r[11:8] <= i_reg_wdata[3:0];
            end
            light_prox_pkg::ADDR_AMB_HI:
               ambient_high_limit_r[11:4] <= i_reg_wdata;
            // Test bytes are stored only; nonzero values are not modelled
            light_prox_pkg::ADDR_TEST_MODE_ONE: test_mode_one_r <= i_reg_wdata;
            light_prox_pkg::ADDR_TEST_MODE_TWO: test_mode_two_r <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   // Registered read data, one cycle after the strobe
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            light_prox_pkg::ADDR_CFG:     o_reg_rdata <= cfg_r;
            light_prox_pkg::ADDR_EVT:
               o_reg_rdata <= {near_event_flag_r, near_persist_count_r,
                               1'b0, ambient_event_flag_r,
                               ambient_persist_count_r, pin_and_r};
            light_prox_pkg::ADDR_NEAR_LO: o_reg_rdata <= near_low_limit_r;
            light_prox_pkg::ADDR_NEAR_HI: o_reg_rdata <= near_high_limit_r;
            light_prox_pkg::ADDR_AMB_LO:
               o_reg_rdata <= ambient_low_limit_r[7:0];
            light_prox_pkg::ADDR_AMB_MIX:
               o_reg_rdata <= {ambient_high_limit_r[3:0],
                               ambient_low_limit_r[11:8]};
            light_prox_pkg::ADDR_AMB_HI:
               o_reg_rdata <= ambient_high_limit_r[11:4];
            light_prox_pkg::ADDR_NEAR_RES: o_reg_rdata <= near_result_r;
            light_prox_pkg::ADDR_AMB_RL:
               o_reg_rdata <= ambient_result_value_r[7:0];
            light_prox_pkg::ADDR_AMB_RH:
               o_reg_rdata <= {4'h0, ambient_result_value_r[11:8]};
            light_prox_pkg::ADDR_TEST_MODE_ONE:   o_reg_rdata <= test_mode_one_r;
            light_prox_pkg::ADDR_TEST_MODE_TWO:   o_reg_rdata <= test_mode_two_r;
            default:                      o_reg_rdata <= 8'h00;
         endcase
      end
   end

   // Proximity sequencer: LED-lit conversion, then idle gap
   assign idle_target = 32'(light_prox_pkg::idle_units(cfg_r[6:4]))
                        * IDLE_UNIT_CYCLES;
   assign near_valid  = (near_state_r == NEAR_CONVERT)
                        && (near_timer_r == 32'(NEAR_CONV_CYCLES - 1));

   always_ff @(posedge i_clock) begin
      if (i_reset || !near_on) begin
         near_state_r <= NEAR_OFF;
         near_timer_r <= 32'h0000_0000;
      end else begin
         near_timer_r <= near_timer_r + 32'h0000_0001;
         case (near_state_r)
            NEAR_OFF: begin
               near_state_r <= NEAR_CONVERT;
               near_timer_r <= 32'h0000_0000;
            end
            NEAR_CONVERT: begin
               if (near_valid) begin
                  near_timer_r <= 32'h0000_0000;
                  // Zero idle keeps conversions back to back with the LED lit throughout
                  near_state_r <= (idle_target == 32'h0000_0000) ?
                                  NEAR_CONVERT : NEAR_IDLE;
               end
            end
            NEAR_IDLE: begin
               if (near_timer_r + 32'h0000_0001 >= idle_target) begin
                  near_state_r <= NEAR_CONVERT;
                  near_timer_r <= 32'h0000_0000;
               end
            end
            default: near_state_r <= NEAR_OFF;
         endcase
      end
   end

   // Ambient sequencer: free-running conversion period while enabled
   assign amb_valid = ambient_sense_on
                      && (amb_timer_r == 32'(AMB_PERIOD_CYCLES - 1));

   always_ff @(posedge i_clock) begin
      if (i_reset || !ambient_sense_on || amb_valid)
         amb_timer_r <= 32'h0000_0000;
      else
         amb_timer_r <= amb_timer_r + 32'h0000_0001;
   end

   // Conversion results; spectrum and span steer the converter
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         near_result_r          <= 8'h00;
         ambient_result_value_r <= 12'h000;
      end else begin
         if (near_valid)
            near_result_r <= near_sync_r;
         if (amb_valid)
            ambient_result_value_r <= amb_sync_r;
      end
   end

   // Proximity hysteresis: once above the high limit, stays tripping down to low; ambient trips outside its window
   assign near_trip = (near_sync_r > near_high_limit_r)
                      || (near_zone_r && (near_sync_r >= near_low_limit_r));
   assign amb_trip  = (amb_sync_r < ambient_low_limit_r)
                      || (amb_sync_r > ambient_high_limit_r);

   always_ff @(posedge i_clock) begin
      if (i_reset)
         near_zone_r <= 1'b0;
      else if (near_valid)
         near_zone_r <= near_trip;
   end

   persist_filter u_near_persist (
      .i_clock        (i_clock),
      .i_reset        (i_reset),
      .i_sample_valid (near_valid),
      .i_trip         (near_trip),
      .i_persist_code (near_persist_count_r),
      .o_event        (near_event)
   );

   persist_filter u_amb_persist (
      .i_clock        (i_clock),
      .i_reset        (i_reset),
      .i_sample_valid (amb_valid),
      .i_trip         (amb_trip),
      .i_persist_code (ambient_persist_count_r),
      .o_event        (amb_event)
   );

   // Sticky flags; an event in the clearing cycle wins over the clear
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         near_event_flag_r    <= 1'b0;
         ambient_event_flag_r <= 1'b0;
      end else begin
         if (near_event)
            near_event_flag_r <= 1'b1;
         else if (evt_wr && !i_reg_wdata[light_prox_pkg::EVT_NEAR_FLAG])
            near_event_flag_r <= 1'b0;
         if (amb_event)
            ambient_event_flag_r <= 1'b1;
         else if (evt_wr && !i_reg_wdata[light_prox_pkg::EVT_AMB_FLAG])
            ambient_event_flag_r <= 1'b0;
      end
   end

   // Front end and pin outputs
   assign o_led_sink_pin    = (near_state_r == NEAR_CONVERT);
   assign o_led_drive_level = cfg_r[light_prox_pkg::CFG_DRIVE];
   assign o_lux_span_select = cfg_r[light_prox_pkg::CFG_SPAN];
   assign o_spectrum_select = cfg_r[light_prox_pkg::CFG_SPECTRUM];
   assign o_event_pin_out   = 1'b0;
   assign o_event_pin_oe    = pin_and_r ?
      (near_event_flag_r && ambient_event_flag_r) :
      (near_event_flag_r || ambient_event_flag_r);

   // Checking helpers: age since enable (ambient: since last result), first proximity result pending
   logic [31:0] near_age_r;
   logic        near_first_r;
   logic [31:0] amb_age_r;

   always_ff @(posedge i_clock) begin
      if (i_reset || !near_on) begin
         near_age_r   <= 32'h0000_0000;
         near_first_r <= 1'b1;
      end else begin
         near_age_r <= near_age_r + 32'h0000_0001;
         if (near_valid)
            near_first_r <= 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset || !ambient_sense_on || amb_valid)
         amb_age_r <= 32'h0000_0000;
      else
         amb_age_r <= amb_age_r + 32'h0000_0001;
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   sequence s_near_clear;
      evt_wr && !i_reg_wdata[light_prox_pkg::EVT_NEAR_FLAG] && !near_event;
   endsequence

   sequence s_near_hold;
      near_event_flag_r && !(evt_wr
         && !i_reg_wdata[light_prox_pkg::EVT_NEAR_FLAG]);
   endsequence

   property p_near_flag_sticky;
      s_near_hold |=> near_event_flag_r;
   endproperty
   a_near_flag_sticky: assert property (p_near_flag_sticky)
      else $error("proximity flag dropped without a clearing write");

   property p_near_flag_clear;
      s_near_clear |=> !near_event_flag_r;
   endproperty
   a_near_flag_clear: assert property (p_near_flag_clear)
      else $error("proximity flag not cleared by zero write");

   property p_event_sets_flag;
      amb_event |=> ambient_event_flag_r;
   endproperty
   a_event_sets_flag: assert property (p_event_sets_flag)
      else $error("ambient flag not set by event");

   property p_pin_or;
      !pin_and_r |-> o_event_pin_oe ==
         (near_event_flag_r || ambient_event_flag_r);
   endproperty
   a_pin_or: assert property (p_pin_or)
      else $error("event pin OR combination wrong");

   property p_pin_and;
      pin_and_r |-> o_event_pin_oe ==
         (near_event_flag_r && ambient_event_flag_r);
   endproperty
   a_pin_and: assert property (p_pin_and)
      else $error("event pin AND combination wrong");

   property p_unmapped_zero;
      i_reg_rd && ((i_reg_addr == light_prox_pkg::ADDR_RESERVED)
         || (i_reg_addr > light_prox_pkg::ADDR_AMB_RH
             && i_reg_addr < light_prox_pkg::ADDR_TEST_MODE_ONE))
      |=> o_reg_rdata == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped address read nonzero");

   property p_result_readback;
      i_reg_rd && (i_reg_addr == light_prox_pkg::ADDR_NEAR_RES)
      |=> o_reg_rdata == $past(near_result_r);
   endproperty
   a_result_readback: assert property (p_result_readback)
      else $error("proximity result readback wrong");

   property p_near_off_dark;
      // Bit 7 set again may restart the LED on the second cycle
      !near_on |=> !o_led_sink_pin ##1 ($past(near_on) || !o_led_sink_pin);
   endproperty
   a_near_off_dark: assert property (p_near_off_dark)
      else $error("LED pulsed while proximity sensing off");

   property p_first_near;
      near_valid && near_first_r |->
         near_age_r == 32'(NEAR_CONV_CYCLES);
   endproperty
   a_first_near: assert property (p_first_near)
      else $error("first proximity result at wrong time");

   property p_amb_period;
      amb_valid |-> amb_age_r == 32'(AMB_PERIOD_CYCLES - 1)
                    && ambient_sense_on;
   endproperty
   a_amb_period: assert property (p_amb_period)
      else $error("ambient result period wrong");

endmodule : light_prox_regs
`default_nettype wire

//--- core/persist_filter.sv
// Persistence filter: fires once a run of tripping conversions is long
// enough. Assumes sample strobes are one-cycle pulses on i_clock.
`timescale 1ns/1ps
`default_nettype none
module persist_filter (
   // Clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_reset,
   // Conversion outcome
   input  wire logic       i_sample_valid,
   input  wire logic       i_trip,
   input  wire logic [1:0] i_persist_code,
   // Event pulse
   output logic            o_event
);
   logic [4:0] run_r;
   logic [4:0] need;
   logic [4:0] run_inc;

   assign need    = light_prox_pkg::persist_need(i_persist_code);
   assign run_inc = run_r + 5'h01;

   // Run length saturates at the largest need so it never wraps
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         run_r   <= 5'h00;
         o_event <= 1'b0;
      end else begin
         o_event <= 1'b0;
         if (i_sample_valid) begin
            if (i_trip) begin
               if (run_inc >= need)
                  o_event <= 1'b1;
               if (run_r < 5'h10)
                  run_r <= run_inc;
            end else begin
               run_r <= 5'h00;
            end
         end
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   property p_no_early_event;
      o_event |-> $past(i_sample_valid) && $past(i_trip)
                  && ($past(run_inc) >= $past(need));
   endproperty
   a_no_early_event: assert property (p_no_early_event)
      else $error("persistence event before enough trips");

   property p_event_fires;
      i_sample_valid && i_trip && (run_inc >= need) |=> o_event;
   endproperty
   a_event_fires: assert property (p_event_fires)
      else $error("persistence event missing");

endmodule : persist_filter
`default_nettype wire
